/* File: hdl/mic_top.sv */
// module: mac interface mode control register with ahb-lite access
//
// Functional notes
// - rx clock delayed one hclk cycle (2 ns skew rounded up) when bit set in rgmii mode
// - tx clock delayed one hclk cycle (2 ns skew rounded up) when bit set in rgmii mode
// - rgmii bit set selects rgmii mode
// - else rmii bit picks rmii or mii
// - clock select: 1 is 50 MHz, 0 is 25
// - strap fields reset from straps, stay writable
// - revision 1.0 holds crs_dv until data ends
// - revision 1.2 toggles crs_dv at packet end
// - overflow bit reads 0 after overflow, cor
// - underflow bit reads 0 after underflow, cor
// - buffer size field sets bit tolerance
// - buffer absorbs rmii clock frequency difference
// - register lives at index 0x0017
`timescale 1ns/1ps
`default_nettype none
module mic_top
  import mic_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [9:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // strap pins, caught after reset release
  input wire logic strap_rx_delay,
  input wire logic strap_tx_delay,
  input wire logic strap_rgmii,
  input wire logic strap_clk_50m,
  input wire logic strap_rmii,
  // receive link: recovered clock and data from the line side
  input wire logic link_clk,
  input wire logic link_rx_data,
  input wire logic link_rx_active,
  // mac-side receive outputs
  output logic rx_clk_out,
  output logic rx_data_out,
  output logic crs_dv,
  // mac-side transmit inputs and the sampled data output
  input wire logic tx_clk_in,
  input wire logic tx_data_in,
  output logic tx_data_sampled,
  // mode outputs
  output mic_mode_t mac_mode,
  output logic ref_clk_50m,
  // interrupt
  output logic irq
);
  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [4:0] s1_q;
  logic [4:0] s2_q;
  logic [4:0] raw;
  assign raw = {link_clk, link_rx_data, link_rx_active, tx_clk_in,
    tx_data_in};
  // two stages for every link and mac transmit pin; straps are not synchronised
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= 5'h0;
      s2_q <= 5'h0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end
  logic lclk;
  logic ldata;
  logic lact;
  logic tclk;
  logic tdata;
  assign {lclk, ldata, lact, tclk, tdata} = s2_q;

  // ---------------------------------------------------------------
  // register fields
  // ---------------------------------------------------------------
  logic [2:0] rsv_hi_q;
  logic rxdly_q;
  logic txdly_q;
  logic rsv10_q;
  logic rgmii_q;
  logic rsv8_q;
  logic clksel_q;
  logic rsv6_q;
  logic rmii_q;
  logic rev_q;
  logic ovf_n_q;
  logic unf_n_q;
  logic [1:0] elas_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  logic strap_done_q;

  // ---------------------------------------------------------------
  // ahb-lite slave
  // ---------------------------------------------------------------
  logic ap_wr_q;
  logic [9:0] ap_addr_q;
  logic take;
  assign take = hsel && hready && htrans[1];
  assign hreadyout = 1'b1; // zero wait states
  assign hresp = 1'b0;
  // latch address phase; data follows next cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_q <= 1'b0;
      ap_addr_q <= 10'h0;
    end else begin
      ap_wr_q <= take && hwrite;
      ap_addr_q <= haddr;
    end
  end
  logic wr_ctrl;
  logic wr_mask;
  logic rd_ctrl;
  logic rd_stat;
  assign wr_ctrl = ap_wr_q && ap_addr_q == MIC_CTRL_ADDR;
  assign wr_mask = ap_wr_q && ap_addr_q == MIC_IRQ_MASK_ADDR;
  // read clears act on the edge that samples hrdata, so no event slips
  // in between the sample and the clear
  assign rd_ctrl = take && !hwrite && haddr == MIC_CTRL_ADDR;
  assign rd_stat = take && !hwrite && haddr == MIC_IRQ_STAT_ADDR;

  // elasticity link
  mic_elastic_if eb ();
  mic_elastic u_elastic (
    .hclk(hclk),
    .hresetn(hresetn),
    .eb(eb)
  );

  // control word as seen by software
  logic [15:0] ctrl_word;
  assign ctrl_word = {rsv_hi_q, rxdly_q, txdly_q, rsv10_q, rgmii_q,
    rsv8_q, clksel_q, rsv6_q, rmii_q, rev_q, ovf_n_q, unf_n_q, elas_q};

  // read data registered in the address-to-data step
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (take && !hwrite) begin
      case (haddr)
        MIC_CTRL_ADDR: hrdata <= {16'h0, ctrl_word};
        MIC_IRQ_STAT_ADDR: hrdata <= {30'h0, irq_stat_q};
        MIC_IRQ_MASK_ADDR: hrdata <= {30'h0, irq_mask_q};
        MIC_ELAS_ADDR: hrdata <= {28'h0, eb.level};
        default: hrdata <= 32'h0;
      endcase
    end
  end

  // writable fields; straps loaded once after reset release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_done_q <= 1'b0;
      rsv_hi_q <= MIC_RSV_HI_RST;
      rxdly_q <= 1'b0;
      txdly_q <= 1'b0;
      rsv10_q <= 1'b0;
      rgmii_q <= 1'b0;
      rsv8_q <= 1'b0;
      clksel_q <= 1'b0;
      rsv6_q <= MIC_RSV6_RST;
      rmii_q <= 1'b0;
      rev_q <= 1'b0;
      elas_q <= MIC_ELAS_RST;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      rxdly_q <= strap_rx_delay;
      txdly_q <= strap_tx_delay;
      rgmii_q <= strap_rgmii;
      clksel_q <= strap_clk_50m;
      rmii_q <= strap_rmii;
    end else if (wr_ctrl) begin
      rsv_hi_q <= hwdata[15:13];
      rxdly_q <= hwdata[MIC_RXDLY_BIT];
      txdly_q <= hwdata[MIC_TXDLY_BIT];
      rsv10_q <= hwdata[10];
      rgmii_q <= hwdata[MIC_RGMII_BIT];
      rsv8_q <= hwdata[8];
      clksel_q <= hwdata[MIC_CLKSEL_BIT];
      rsv6_q <= hwdata[6];
      rmii_q <= hwdata[MIC_RMII_BIT];
      rev_q <= hwdata[MIC_REV_BIT];
      elas_q <= hwdata[1:0];
    end
  end

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  always_comb begin
    if (rgmii_q) begin
      mac_mode = MIC_MODE_RGMII;
    end else if (rmii_q) begin
      mac_mode = MIC_MODE_RMII;
    end else begin
      mac_mode = MIC_MODE_MII;
    end
  end
  assign ref_clk_50m = clksel_q;

  // ---------------------------------------------------------------
  // link clock edges and skew lines
  // ---------------------------------------------------------------
  logic lclk_d_q;
  logic tclk_d_q;
  logic lrise;
  logic trise;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lclk_d_q <= 1'b0;
      tclk_d_q <= 1'b0;
    end else begin
      lclk_d_q <= lclk;
      tclk_d_q <= tclk;
    end
  end
  assign lrise = lclk && !lclk_d_q;
  assign trise = tclk && !tclk_d_q;

  // receive clock held back by the skew count when enabled
  logic [MIC_SKEW_CYC-1:0] rxclk_sh_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rxclk_sh_q <= '0;
      rx_clk_out <= 1'b0;
      rx_data_out <= 1'b0;
    end else begin
      rxclk_sh_q <= MIC_SKEW_CYC'({rxclk_sh_q, lclk});
      rx_data_out <= ldata;
      // delayed clock vs aligned clock
      rx_clk_out <= (rgmii_q && rxdly_q) ? rxclk_sh_q[MIC_SKEW_CYC-1]
        : lclk;
    end
  end

  // tx data sampled on the delayed or aligned clock edge
  logic [MIC_SKEW_CYC-1:0] trise_sh_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trise_sh_q <= '0;
      tx_data_sampled <= 1'b0;
    end else begin
      trise_sh_q <= MIC_SKEW_CYC'({trise_sh_q, trise});
      if ((rgmii_q && txdly_q) ? trise_sh_q[MIC_SKEW_CYC-1] : trise) begin
        tx_data_sampled <= tdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // rmii receive path: elasticity and crs_dv
  // ---------------------------------------------------------------
  logic rmii_on;
  assign rmii_on = mac_mode == MIC_MODE_RMII;
  assign eb.tol_bits = mic_tol_bits(elas_q);
  assign eb.enable = rmii_on && lact;
  assign eb.wr_bit = lrise; // recovered bits
  assign eb.rd_bit = rmii_on && lact && trise; // mac transmit clock in

  // end of packet: revision 1.0 holds steady, 1.2 toggles while draining
  // drain lasts the bits still held at the centre of the buffer
  logic act_d_q;
  logic [2:0] drain_q;
  logic tog_q;
  logic drop;
  assign drop = act_d_q && !lact && rmii_on;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_d_q <= 1'b0;
      drain_q <= 3'h0;
      tog_q <= 1'b0;
      crs_dv <= 1'b0;
    end else begin
      act_d_q <= lact;
      if (drop) begin
        drain_q <= eb.tol_bits;
      end else if (drain_q != 3'h0 && trise) begin
        drain_q <= drain_q - 3'h1; // one held bit handed over
      end
      if (drop) begin
        tog_q <= 1'b0;
      end else if (trise) begin
        tog_q <= !tog_q;
      end
      if (!rmii_on) begin
        crs_dv <= lact;
      end else if (lact) begin
        crs_dv <= 1'b1;
      end else if (drop) begin
        crs_dv <= rev_q; // 1.0 holds with no gap
      end else if (drain_q != 3'h0) begin
        crs_dv <= rev_q ? 1'b1 : tog_q;
      end else begin
        crs_dv <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // status bits and interrupt
  // ---------------------------------------------------------------
  // active-low sticky flags; a new event beats the read clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovf_n_q <= 1'b1;
      unf_n_q <= 1'b1;
    end else begin
      if (eb.ovf) begin
        ovf_n_q <= 1'b0;
      end else if (rd_ctrl) begin
        ovf_n_q <= 1'b1;
      end
      if (eb.unf) begin
        unf_n_q <= 1'b0;
      end else if (rd_ctrl) begin
        unf_n_q <= 1'b1;
      end
    end
  end

  // interrupt status cleared on read, mask set by software
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_q <= 2'h0;
      irq_mask_q <= 2'h0;
    end else begin
      irq_stat_q <= (rd_stat ? 2'h0 : irq_stat_q) | {eb.unf, eb.ovf};
      if (wr_mask) begin
        irq_mask_q <= hwdata[1:0];
      end
    end
  end
  assign irq = |(irq_stat_q & irq_mask_q);
endmodule
`default_nettype wire

/* File: hdl/mic_pkg.sv */
// package: register map, field positions, reset values and timing for mic
package mic_pkg;
  // register map (index 0x0017, byte address = 4 * index)
  localparam logic [7:0] MIC_CTRL_IDX = 8'h17;
  localparam logic [9:0] MIC_CTRL_ADDR = {MIC_CTRL_IDX, 2'b00};
  localparam logic [9:0] MIC_IRQ_STAT_ADDR = 10'h0a0;
  localparam logic [9:0] MIC_IRQ_MASK_ADDR = 10'h0a4;
  localparam logic [9:0] MIC_ELAS_ADDR = 10'h0a8;
  // field positions of mac_interface_control
  localparam int MIC_RXDLY_BIT = 12;
  localparam int MIC_TXDLY_BIT = 11;
  localparam int MIC_RGMII_BIT = 9;
  localparam int MIC_CLKSEL_BIT = 7;
  localparam int MIC_RMII_BIT = 5;
  localparam int MIC_REV_BIT = 4;
  localparam int MIC_OVF_BIT = 3;
  localparam int MIC_UNF_BIT = 2;
  // reset values of the non-strap fields
  localparam logic [2:0] MIC_RSV_HI_RST = 3'h2;
  localparam logic MIC_RSV6_RST = 1'b1;
  localparam logic [1:0] MIC_ELAS_RST = 2'h1;
  // timing: internal skew of 2 ns
  localparam int MIC_CLK_PS = 40000;
  localparam int MIC_SKEW_PS = 2000;
  localparam int MIC_SKEW_CYC = (MIC_SKEW_PS + MIC_CLK_PS - 1) / MIC_CLK_PS;
  // interrupt status bit positions
  localparam int MIC_IRQ_OVF = 0;
  localparam int MIC_IRQ_UNF = 1;
  // interface modes
  typedef enum logic [1:0] {MIC_MODE_MII, MIC_MODE_RMII, MIC_MODE_RGMII}
    mic_mode_t;
  // tolerance in bits per elasticity setting
  function automatic logic [2:0] mic_tol_bits(input logic [1:0] sz);
    case (sz)
      2'h0: mic_tol_bits = 3'h5;
      2'h1: mic_tol_bits = 3'h2;
      2'h2: mic_tol_bits = 3'h3;
      default: mic_tol_bits = 3'h4;
    endcase
  endfunction
endpackage

/* File: hdl/mic_elastic_if.sv */
// interface: elasticity buffer controls and results
`timescale 1ns/1ps
`default_nettype none
interface mic_elastic_if;
  logic [2:0] tol_bits;
  logic enable;
  logic wr_bit;
  logic rd_bit;
  logic ovf;
  logic unf;
  logic [3:0] level;
  modport ctrl (output tol_bits, output enable, output wr_bit,
    output rd_bit, input ovf, input unf, input level);
  modport buf_side (input tol_bits, input enable, input wr_bit,
    input rd_bit, output ovf, output unf, output level);
endinterface
`default_nettype wire

/* File: hdl/mic_elastic.sv */
// module: occupancy tracker of the rmii receive elasticity buffer
`timescale 1ns/1ps
`default_nettype none
module mic_elastic
  import mic_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control and status
  mic_elastic_if.buf_side eb
);
  logic [3:0] fill_q;
  logic [3:0] mid;
  assign mid = {1'b0, eb.tol_bits};
  assign eb.level = fill_q;

  // tracks bits held; centre preload gives +-tol of slip
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fill_q <= 4'h0;
      eb.ovf <= 1'b0;
      eb.unf <= 1'b0;
    end else begin
      eb.ovf <= 1'b0;
      eb.unf <= 1'b0;
      if (!eb.enable) begin
        fill_q <= mid;
      end else if (eb.wr_bit && !eb.rd_bit) begin
        if (fill_q >= (mid << 1)) begin
          eb.ovf <= 1'b1;
          fill_q <= mid;
        end else begin
          fill_q <= fill_q + 4'h1;
        end
      end else if (eb.rd_bit && !eb.wr_bit) begin
        if (fill_q == 4'h0) begin
          eb.unf <= 1'b1;
          fill_q <= mid;
        end else begin
          fill_q <= fill_q - 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/mic_monitor.sv */
// checker: bus, mode and receive relations at the mic_top ports
`timescale 1ns/1ps
`default_nettype none
module mic_monitor
  import mic_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [9:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // link and mode
  input wire logic link_rx_active,
  input wire logic crs_dv,
  input wire mic_mode_t mac_mode,
  input wire logic ref_clk_50m
);
  // ------------------------
  // read tracking
  // ------------------------
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd_take;
  logic rd_ctl_q;
  logic rd_unm_q;
  assign rd_take = hsel && hready && htrans[1] && !hwrite;
  // data phase flags, so each check lands on the cycle hrdata stands
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ctl_q <= 1'b0;
      rd_unm_q <= 1'b0;
    end else begin
      rd_ctl_q <= rd_take && haddr == MIC_CTRL_ADDR;
      rd_unm_q <= rd_take && !(haddr inside {MIC_CTRL_ADDR,
        MIC_IRQ_STAT_ADDR, MIC_IRQ_MASK_ADDR, MIC_ELAS_ADDR});
    end
  end
  // ------------------------
  // assertions
  // ------------------------
  zero_wait_a: assert property (hreadyout)
    else $error("hreadyout low");
  okay_resp_a: assert property (!hresp)
    else $error("hresp not okay");
  unmapped_zero_a: assert property (rd_unm_q |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  ctl_upper_a: assert property (rd_ctl_q |-> hrdata[31:16] == 16'h0)
    else $error("control read upper half set");
  mode_decode_a: assert property (rd_ctl_q |-> mac_mode ==
    (hrdata[9] ? MIC_MODE_RGMII : hrdata[5] ? MIC_MODE_RMII : MIC_MODE_MII))
    else $error("mode disagrees with register");
  mode_legal_a: assert property (mac_mode inside {MIC_MODE_MII,
    MIC_MODE_RMII, MIC_MODE_RGMII})
    else $error("illegal mode code");
  clk_sel_a: assert property (rd_ctl_q |-> ref_clk_50m == hrdata[7])
    else $error("reference select disagrees");
  rdata_hold_a: assert property (!rd_take |=> $stable(hrdata))
    else $error("read data moved without a read");
  crs_follow_a: assert property ($rose(link_rx_active) |-> ##[1:6] crs_dv)
    else $error("carrier not raised");
endmodule
bind mic_top mic_monitor i_mic_monitor (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata, .link_rx_active,
  .crs_dv, .mac_mode, .ref_clk_50m);
`default_nettype wire

/* File: tb/mic_mac_model.sv */
// model: mac transmit side, its clock runs only while sending
`timescale 1ns/1ps
`default_nettype none
module mic_mac_model (
  // clock and control
  input wire logic hclk,
  input wire logic run,
  // transmit pins toward the block
  output logic tx_clk,
  output logic tx_data
);
  logic [1:0] div_q;
  initial begin
    div_q = 2'h0;
    tx_clk = 1'b0;
    tx_data = 1'b0;
  end
  // clock at hclk/8, parked low between frames; drains the buffer
  always @(posedge hclk) begin
    div_q <= run ? div_q + 2'h1 : 2'h0;
    if (!run)
      tx_clk <= 1'b0;
    else if (div_q == 2'h3)
      tx_clk <= ~tx_clk;
  end
  // idle line never shows a steady last value
  always @(posedge hclk) begin
    if (!run || (div_q == 2'h3 && tx_clk))
      tx_data <= ~tx_data;
  end
endmodule
`default_nettype wire

/* File: tb/mic_tb_top.sv */
// testbench: straps, modes, bus access and rmii receive events
`timescale 1ns/1ps
`default_nettype none
module mic_tb_top;
  import mic_pkg::*;
  // ------------------------
  // signals and instances
  // ------------------------
  logic hclk, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic hreadyout, hresp, irq, rx_clk_out, rx_data_out, crs_dv;
  logic [9:0] haddr = 10'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  logic strap_rx_delay = 1'b0, strap_tx_delay = 1'b0, strap_rgmii = 1'b0;
  logic strap_clk_50m = 1'b0, strap_rmii = 1'b0, link_clk, link_rx_data;
  logic link_rx_active = 1'b0, link_on = 1'b0, mac_run = 1'b0;
  logic tx_clk_in, tx_data_in, tx_data_sampled, ref_clk_50m;
  mic_mode_t mac_mode;
  int bad_count = 0, tests_run = 0, tg;
  mic_top i_mic_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .strap_rx_delay, .strap_tx_delay, .strap_rgmii, .strap_clk_50m,
    .strap_rmii, .link_clk, .link_rx_data, .link_rx_active, .rx_clk_out,
    .rx_data_out, .crs_dv, .tx_clk_in, .tx_data_in, .tx_data_sampled,
    .mac_mode, .ref_clk_50m, .irq);
  mic_mac_model i_mic_mac_model (.hclk, .run(mac_run), .tx_clk(tx_clk_in),
    .tx_data(tx_data_in));
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // link clock, phase-free of hclk, still while link_on is low
  initial begin
    link_clk = 1'b0;
    link_rx_data = 1'b0;
    #7;
    forever begin
      #160;
      link_clk = link_on ? ~link_clk : 1'b0;
      link_rx_data = ~link_rx_data;
    end
  end
  // ------------------------
  // shared tasks
  // ------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask
  // one single transfer; waits on hready, bounded
  task automatic ahb(input logic wr, input logic [9:0] a,
      input logic [31:0] wd, output logic [31:0] r);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    r = hrdata;
    if (n >= 40) begin
      bad_count++;
      conclude();
    end
  endtask
  // straps {rx, tx, rgmii, clk50, rmii} held across release
  task automatic t_straps(input logic [4:0] s, input logic [31:0] ev,
      input mic_mode_t em);
    {strap_rx_delay, strap_tx_delay, strap_rgmii, strap_clk_50m,
      strap_rmii} <= s;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    ahb(1'b0, MIC_CTRL_ADDR, 32'h0, rd);
    chk("ctl reset", ev, rd);
    chk("mode", {30'h0, em}, {30'h0, mac_mode});
    chk("ref clk", {31'h0, s[1]}, {31'h0, ref_clk_50m});
  endtask
  // reserved bits read back as written on every write; bits 3:2 read as 1
  task automatic t_modes();
    logic [31:0] wv [4];
    mic_mode_t md [4];
    wv = '{32'h4240, 32'h40a1, 32'h5a22, 32'h4093};
    md = '{MIC_MODE_RGMII, MIC_MODE_RMII, MIC_MODE_RGMII, MIC_MODE_MII};
    for (int i = 0; i < 4; i++) begin
      ahb(1'b1, MIC_CTRL_ADDR, wv[i], rd);
      ahb(1'b0, MIC_CTRL_ADDR, 32'h0, rd);
      chk("ctl readback", wv[i] | 32'hc, rd);
      chk("mode", {30'h0, md[i]}, {30'h0, mac_mode});
      chk("ref clk", {31'h0, wv[i][7]}, {31'h0, ref_clk_50m});
    end
  endtask
  // rx clock change lags the rx data change only when delay is on
  task automatic t_rx_skew(input logic [31:0] wv, input int exp);
    logic p, c;
    int k, n;
    ahb(1'b1, MIC_CTRL_ADDR, wv, rd);
    link_on <= 1'b1;
    repeat (20) @(posedge hclk);
    p = rx_data_out;
    c = rx_clk_out;
    k = 0;
    while (rx_data_out === p && k < 16) begin
      c = rx_clk_out;
      @(posedge hclk);
      k++;
    end
    n = 0;
    while (rx_clk_out === c && n < 8) begin
      @(posedge hclk);
      n++;
    end
    chk("rx clock skew", exp, n);
    link_on <= 1'b0;
  endtask
  task automatic t_unmapped();
    ahb(1'b1, 10'h3f0, 32'hffff_ffff, rd);
    ahb(1'b0, 10'h3f0, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
  endtask
  // rmii frame; counts carrier toggles while the frame runs
  task automatic frame(input logic rev, input logic mac, input logic lnk);
    logic p;
    ahb(1'b1, MIC_CTRL_ADDR, 32'h4061 | {27'h0, rev, 4'h0}, rd);
    link_rx_active <= 1'b1;
    mac_run <= mac;
    link_on <= lnk;
    repeat (8) @(posedge hclk);
    tg = 0;
    p = crs_dv;
    repeat (240) begin
      @(posedge hclk);
      tg += (crs_dv !== p);
      p = crs_dv;
    end
    if (rev)
      chk("crs_dv held", 32'h1, {31'h0, crs_dv});
    link_rx_active <= 1'b0;
    link_on <= 1'b0;
    mac_run <= 1'b1; // the drain is paced by the mac clock
    // tail: carrier rises count as end-of-packet toggles
    repeat (40) begin
      @(posedge hclk);
      tg += (crs_dv && !p);
      p = crs_dv;
    end
    mac_run <= 1'b0;
    repeat (4) @(posedge hclk);
    chk("crs_dv idle", 32'h0, {31'h0, crs_dv});
  endtask
  task automatic t_events();
    ahb(1'b1, MIC_IRQ_MASK_ADDR, 32'h3, rd);
    frame(1'b1, 1'b0, 1'b1);
    chk("toggles rev 1.0", 32'h0, tg);
    chk("irq overflow", 32'h1, {31'h0, irq});
    ahb(1'b0, MIC_CTRL_ADDR, 32'h0, rd);
    chk("overflow flag", 32'h0, {31'h0, rd[3]});
    ahb(1'b0, MIC_CTRL_ADDR, 32'h0, rd);
    chk("overflow cleared", 32'h1, {31'h0, rd[3]});
    ahb(1'b0, MIC_IRQ_STAT_ADDR, 32'h0, rd);
    chk("status overflow", 32'h1, rd & 32'h1);
    repeat (2) @(posedge hclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    frame(1'b0, 1'b1, 1'b0);
    chk("toggles rev 1.2", 32'h1, {31'h0, tg > 0});
    ahb(1'b0, MIC_CTRL_ADDR, 32'h0, rd);
    chk("underflow flag", 32'h0, {31'h0, rd[2]});
    ahb(1'b1, MIC_IRQ_MASK_ADDR, 32'h0, rd);
    ahb(1'b0, MIC_IRQ_STAT_ADDR, 32'h0, rd);
    chk("status underflow", 32'h2, rd & 32'h2);
    frame(1'b1, 1'b0, 1'b1);
    chk("irq masked", 32'h0, {31'h0, irq});
  endtask
  // ------------------------
  // main sequence
  // ------------------------
  initial begin
    t_straps(5'b10011, 32'h50ed, MIC_MODE_RMII);
    t_straps(5'b01100, 32'h4a4d, MIC_MODE_RGMII);
    t_modes();
    t_rx_skew(32'h4240, 0);
    t_rx_skew(32'h5240, MIC_SKEW_CYC);
    t_unmapped();
    t_events();
    conclude();
  end
endmodule
`default_nettype wire
